// *** logic/apds_pkg.sv ***
package apds_pkg;
  localparam int NUM_PINS = 12;
  localparam int REG_WIDTH = 16;
  localparam logic [11:0] ADDR_PIN_SELECT = 12'h000;
  localparam logic [11:0] ADDR_PAIR_CTRL0 = 12'h004;
  localparam logic [15:0] PIN_SELECT_MASK = 16'h0FFF;
  localparam logic [15:0] PIN_SELECT_RESET = 16'h0000;
  localparam logic [15:0] PAIR_CTRL0_RESET = 16'h0000;
  localparam int PAIR_SRC_LSB = 0;
  localparam int PAIR_SW_TRIG = 5;
  localparam int PAIR_PEND = 6;
  localparam int PAIR_IRQ_EN = 7;
  localparam int PAIR1_OFS = 8;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apds_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apds_apb_rsp_type;
endpackage

// *** logic/apds_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module apds_sync #(
  parameter int WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } apds_sync_state_type;
  apds_sync_state_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Accept a change only once two later stages agree, filtering a settling glitch
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.out;
endmodule
`default_nettype wire

// *** logic/apds_reg16.sv ***
`timescale 1ns/1ps
`default_nettype none
module apds_reg16 #(
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data
);
  typedef struct packed {
    logic [15:0] val;
  } apds_reg_state_type;
  apds_reg_state_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.val = wr_data & WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.val;
endmodule
`default_nettype wire

// *** logic/apds_top.sv ***
// What this block does
// (RL1) Twelve pin select bits, positions 11 to 0
// (RL2) Bit one: digital, port read enabled
// (RL3) Digital pin: converter channel sees analog ground
// (RL4) Bit zero: analog, port read disabled
// (RL5) Analog pin: converter samples pin voltage
// (RL6) Upper four bits read zero, ignore writes
// (RL7) Reset clears all bits: analog mode
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module apds_top #(
  parameter int NUM_PINS = apds_pkg::NUM_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire apds_pkg::apds_apb_req_type apb_req,
  output apds_pkg::apds_apb_rsp_type apb_rsp,
  input wire logic [NUM_PINS-1:0] pin_level,
  output logic [NUM_PINS-1:0] port_read_data,
  output logic [NUM_PINS-1:0] port_read_enable,
  output logic [NUM_PINS-1:0] mux_to_analog_ground,
  output logic [NUM_PINS-1:0] mux_to_pin,
  output logic [15:0] conversion_pair_control_0
);
  typedef struct packed {
    apds_pkg::apds_apb_rsp_type rsp;
    logic [NUM_PINS-1:0] rd_en;
    logic [NUM_PINS-1:0] gnd;
    logic [NUM_PINS-1:0] pin;
    logic [NUM_PINS-1:0] rdata;
  } apds_top_state_type;
  apds_top_state_type st_q, st_d;

  logic [15:0] pin_select_q;
  logic [15:0] pair_ctrl_q;
  logic [NUM_PINS-1:0] pin_sync;
  logic wr_access;
  logic wr_pin_select;
  logic wr_pair_ctrl;
  logic [NUM_PINS-1:0] pin_digital_select_bits;

  // Writes take effect in the access cycle; slave answers with zero wait states
  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_pin_select = wr_access && (apb_req.paddr == apds_pkg::ADDR_PIN_SELECT);
  assign wr_pair_ctrl = wr_access && (apb_req.paddr == apds_pkg::ADDR_PAIR_CTRL0);

  apds_reg16 #(
    .WMASK(apds_pkg::PIN_SELECT_MASK) // see (RL6)
  ) u_pin_select (
    .pclk(pclk),
    .presetn(presetn), // see (RL7)
    .wr_en(wr_pin_select),
    .wr_data(apb_req.pwdata[15:0]),
    .rd_data(pin_select_q)
  );

  // Pair control is held only; its trigger behaviour lives elsewhere
  apds_reg16 #(
    .WMASK(16'hFFFF)
  ) u_pair_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_pair_ctrl),
    .wr_data(apb_req.pwdata[15:0]),
    .rd_data(pair_ctrl_q)
  );

  apds_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_level),
    .sync_out(pin_sync)
  );

  assign pin_digital_select_bits = pin_select_q[NUM_PINS-1:0]; // see (RL1)

  always_comb begin
    st_d = st_q;
    st_d.rsp.pready = apb_req.psel && !apb_req.penable;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable) begin
      if (!apb_req.pwrite) begin
        unique case (apb_req.paddr)
          apds_pkg::ADDR_PIN_SELECT: st_d.rsp.prdata = {16'h0000, pin_select_q}; // see (RL6)
          apds_pkg::ADDR_PAIR_CTRL0: st_d.rsp.prdata = {16'h0000, pair_ctrl_q};
          default: st_d.rsp.prdata = 32'h0000_0000;
        endcase
      end
      st_d.rsp.pslverr = (apb_req.paddr != apds_pkg::ADDR_PIN_SELECT) &&
                         (apb_req.paddr != apds_pkg::ADDR_PAIR_CTRL0);
    end else if (!apb_req.psel) begin
      st_d.rsp.pready = 1'b0;
    end
    // Outputs follow the select register one cycle after the write lands
    st_d.rd_en = pin_digital_select_bits; // see (RL2) see (RL4)
    st_d.gnd = pin_digital_select_bits; // see (RL3)
    st_d.pin = ~pin_digital_select_bits; // see (RL5)
    st_d.rdata = pin_sync & pin_digital_select_bits; // see (RL2) see (RL4)
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.pin <= '1; // see (RL7)
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp = st_q.rsp;
  assign port_read_enable = st_q.rd_en;
  assign mux_to_analog_ground = st_q.gnd;
  assign mux_to_pin = st_q.pin;
  assign port_read_data = st_q.rdata;
  assign conversion_pair_control_0 = pair_ctrl_q;

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      pin_select_q[15:12] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved select bits nonzero"); // see (RL6)

  property p_write_lands;
    @(posedge pclk) disable iff (!presetn)
      wr_pin_select |=> pin_select_q == ($past(apb_req.pwdata[15:0]) & apds_pkg::PIN_SELECT_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Select write not stored"); // see (RL1)

  property p_digital_read;
    @(posedge pclk) disable iff (!presetn)
      pin_select_q[0] |=> port_read_enable[0];
  endproperty
  a_digital_read: assert property (p_digital_read) else $error("Digital pin read not enabled"); // see (RL2)

  property p_digital_ground;
    @(posedge pclk) disable iff (!presetn)
      pin_select_q[NUM_PINS-1] |=> mux_to_analog_ground[NUM_PINS-1] && !mux_to_pin[NUM_PINS-1];
  endproperty
  a_digital_ground: assert property (p_digital_ground) else $error("Digital pin not grounded"); // see (RL3)

  property p_analog_noread;
    @(posedge pclk) disable iff (!presetn)
      !pin_select_q[0] |=> !port_read_enable[0] && port_read_data[0] == 1'b0;
  endproperty
  a_analog_noread: assert property (p_analog_noread) else $error("Analog pin read enabled"); // see (RL4)

  property p_analog_sample;
    @(posedge pclk) disable iff (!presetn)
      (mux_to_pin ^ mux_to_analog_ground) == '1;
  endproperty
  a_analog_sample: assert property (p_analog_sample) else $error("Mux select not exclusive"); // see (RL5)

  property p_read_back;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == apds_pkg::ADDR_PIN_SELECT)
        |=> apb_rsp.pready && apb_rsp.prdata[31:12] == 20'h00000;
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read upper bits nonzero"); // see (RL6)

  property p_reset_analog;
    @(posedge pclk) $rose(presetn) |-> pin_select_q == 16'h0000 && port_read_enable == '0;
  endproperty
  a_reset_analog: assert property (p_reset_analog) else $error("Reset left pins digital"); // see (RL7)

  property p_reset_mux;
    @(posedge pclk) $rose(presetn) |->
      mux_to_pin == '1 && mux_to_analog_ground == '0 && port_read_data == '0;
  endproperty
  a_reset_mux: assert property (p_reset_mux) else $error("Reset left channels grounded"); // see (RL7)

  // Zero wait states: every setup cycle is answered in the access cycle after it
  property p_ready_after_setup;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("Setup not answered");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("Error without ready");

  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
      !apb_rsp.pready |-> !apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Response busy while idle");

  property p_read_err_zero;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_read_err_zero: assert property (p_read_err_zero) else $error("Error read data nonzero");

  property p_read_upper;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("Read upper half nonzero"); // see (RL6)

  property p_read_select;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == apds_pkg::ADDR_PIN_SELECT)
        |=> apb_rsp.prdata == {16'h0000, $past(pin_select_q)};
  endproperty
  a_read_select: assert property (p_read_select) else $error("Select read data wrong"); // see (RL1)

  property p_pair_read;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == apds_pkg::ADDR_PAIR_CTRL0)
        |=> apb_rsp.prdata == {16'h0000, $past(pair_ctrl_q)};
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("Pair read data wrong");

  // Unmapped addresses answer with an error and leave both registers alone
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && apb_req.paddr != apds_pkg::ADDR_PIN_SELECT &&
       apb_req.paddr != apds_pkg::ADDR_PAIR_CTRL0) |=> apb_rsp.pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped access not refused");

  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && (apb_req.paddr == apds_pkg::ADDR_PIN_SELECT ||
       apb_req.paddr == apds_pkg::ADDR_PAIR_CTRL0)) |=> !apb_rsp.pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("Mapped access refused");

  property p_unmapped_write_ignored;
    @(posedge pclk) disable iff (!presetn)
      (wr_access && apb_req.paddr != apds_pkg::ADDR_PIN_SELECT && apb_req.paddr != apds_pkg::ADDR_PAIR_CTRL0)
        |=> $stable(pin_select_q) && $stable(pair_ctrl_q);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("Unmapped write stored");

  property p_select_hold;
    @(posedge pclk) disable iff (!presetn)
      !wr_pin_select |=> $stable(pin_select_q);
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("Select changed without write"); // see (RL1)

  property p_write_reserved;
    @(posedge pclk) disable iff (!presetn)
      (wr_pin_select && apb_req.pwdata[15:12] != 4'h0) |=> pin_select_q[15:12] == 4'h0;
  endproperty
  a_write_reserved: assert property (p_write_reserved) else $error("Reserved write stored"); // see (RL6)

  property p_pair_write;
    @(posedge pclk) disable iff (!presetn)
      wr_pair_ctrl |=> pair_ctrl_q == $past(apb_req.pwdata[15:0]);
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("Pair write not stored");

  property p_pair_hold;
    @(posedge pclk) disable iff (!presetn)
      !wr_pair_ctrl |=> $stable(pair_ctrl_q);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("Pair changed without write");

  property p_rdata_analog_zero;
    @(posedge pclk) disable iff (!presetn)
      (port_read_data & ~port_read_enable) == '0;
  endproperty
  a_rdata_analog_zero: assert property (p_rdata_analog_zero) else $error("Analog pin level leaked"); // see (RL4)

  property p_ground_vs_read;
    @(posedge pclk) disable iff (!presetn)
      mux_to_analog_ground == port_read_enable;
  endproperty
  a_ground_vs_read: assert property (p_ground_vs_read) else $error("Ground and read disagree"); // see (RL3)

  // One checker set per pin, so no channel can pick up a neighbour's select bit
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin_chk
    property p_pin_read_en;
      @(posedge pclk) disable iff (!presetn)
        port_read_enable[g] == $past(pin_digital_select_bits[g]);
    endproperty
    a_pin_read_en: assert property (p_pin_read_en) else $error("Pin read enable wrong"); // see (RL2) see (RL4)

    property p_pin_ground;
      @(posedge pclk) disable iff (!presetn)
        mux_to_analog_ground[g] == $past(pin_digital_select_bits[g]);
    endproperty
    a_pin_ground: assert property (p_pin_ground) else $error("Pin ground select wrong"); // see (RL3)

    property p_pin_sample;
      @(posedge pclk) disable iff (!presetn)
        mux_to_pin[g] == !$past(pin_digital_select_bits[g]);
    endproperty
    a_pin_sample: assert property (p_pin_sample) else $error("Pin sample select wrong"); // see (RL5)

    property p_pin_gate;
      @(posedge pclk) disable iff (!presetn)
        port_read_data[g] == ($past(pin_sync[g]) && $past(pin_digital_select_bits[g]));
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("Pin read data wrong"); // see (RL2) see (RL4)
  end
endmodule
`default_nettype wire

// *** verification/apds_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module apds_pin_model (
  input wire logic [11:0] pattern,
  output logic [11:0] pin_level
);
  // Pins switch at once; the design's synchroniser must absorb any skew
  assign pin_level = pattern;
endmodule
`default_nettype wire

// *** verification/tb_apds_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_apds_top;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  apds_pkg::apds_apb_req_type apb_req = '0;
  apds_pkg::apds_apb_rsp_type apb_rsp;
  logic [11:0] pattern = 12'h000;
  logic [11:0] pin_level, port_read_data, port_read_enable, mux_to_analog_ground, mux_to_pin;
  logic [15:0] conversion_pair_control_0;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int samples_checked = 0;

  apds_pin_model i_pins (.pattern(pattern), .pin_level(pin_level));
  apds_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_level(pin_level), .port_read_data(port_read_data), .port_read_enable(port_read_enable),
    .mux_to_analog_ground(mux_to_analog_ground), .mux_to_pin(mux_to_pin),
    .conversion_pair_control_0(conversion_pair_control_0));

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: wr, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'h1;
    // No count here: only the watchdog ends a wait on a dead slave
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'h1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'h0;
    apb_req.penable <= 1'h0;
  endtask

  task automatic outs(input logic [11:0] sel);
    repeat (2) @(negedge pclk);
    chk({20'h0, port_read_enable}, {20'h0, sel});
    chk({20'h0, mux_to_analog_ground}, {20'h0, sel});
    chk({20'h0, mux_to_pin}, {20'h0, ~sel});
  endtask

  task automatic pins(input logic [11:0] p, input logic [11:0] exp);
    @(posedge pclk);
    pattern <= p;
    repeat (8) @(negedge pclk);
    chk({20'h0, port_read_data}, {20'h0, exp});
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    outs(12'h000);
    apb(1'h0, apds_pkg::ADDR_PIN_SELECT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, apds_pkg::ADDR_PIN_SELECT, 32'h0000FA5C);
    outs(12'hA5C);
    apb(1'h0, apds_pkg::ADDR_PIN_SELECT, 32'h0);
    chk(rd, 32'h00000A5C);
    pins(12'hFFF, 12'hA5C);
    pins(12'h3C3, 12'h240);
    apb(1'h1, apds_pkg::ADDR_PIN_SELECT, 32'hFFFF0FFF);
    outs(12'hFFF);
    apb(1'h1, apds_pkg::ADDR_PIN_SELECT, 32'h0000F000);
    outs(12'h000);
    apb(1'h0, apds_pkg::ADDR_PIN_SELECT, 32'h0);
    chk(rd, 32'h0);
    pins(12'hFFF, 12'h000);
    apb(1'h1, apds_pkg::ADDR_PAIR_CTRL0, 32'h0000BEEF);
    apb(1'h0, apds_pkg::ADDR_PAIR_CTRL0, 32'h0);
    chk(rd, 32'h0000BEEF);
    chk({16'h0, conversion_pair_control_0}, 32'h0000BEEF);
    apb(1'h1, 12'h008, 32'h0000FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, apds_pkg::ADDR_PIN_SELECT, 32'h00000555);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    outs(12'h000);
    apb(1'h0, apds_pkg::ADDR_PIN_SELECT, 32'h0);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
